// *** core/frequency_protection_element.sv ***
// six frequency protection elements over three line-to-line voltages
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
module frequency_protection_element #(
	parameter int TICK_CYCLES = freq_prot_pkg::TICK_CYCLES
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// voltage samples from the converter logic
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] voltage_line1_to_line2,
	input  wire logic signed [15:0] voltage_line2_to_line3,
	input  wire logic signed [15:0] voltage_line3_to_line1,
	// external blocking, one per element
	input  wire logic [5:0]         ext_block,
	// register port
	input  wire logic [7:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_we,
	input  wire logic               reg_re,
	output logic [31:0]             reg_rdata,
	// protection outputs
	output logic [5:0]              alarm,
	output logic [5:0]              trip,
	output logic                    freq_blocked
);
	typedef struct packed {
		logic [31:0]                          tick_cnt;
		logic [5:0]                           blk_s1;
		logic [5:0]                           blk_s2;
		logic [15:0]                          uv_thr;
		logic [3:0]                           win_meas;
		logic [3:0]                           win_in;
		logic [3:0]                           win_out;
		freq_prot_pkg::mode_type [5:0]        mode;
		freq_prot_pkg::pol_type [5:0]         pol;
		logic [5:0][15:0]                     fthr;
		logic [5:0][15:0]                     gthr;
		logic [5:0][15:0]                     delay;
		logic [5:0][15:0]                     timer;
		logic [5:0]                           alarm;
		logic [5:0]                           trip;
		logic                                 all_low;
		logic [9:0]                           recov;
		logic [31:0]                          rdata;
	} core_state_type;

	core_state_type s_r;
	core_state_type s_nxt;

	logic signed [2:0][15:0] volts;
	logic [2:0][15:0]        ph_freq;
	logic [2:0][15:0]        ph_grad;
	logic [2:0]              ph_low;
	logic                    tick;
	logic                    blocked;
	logic                    freq_zero;
	logic                    grad_zero;

	assign volts = {voltage_line3_to_line1, voltage_line2_to_line3, voltage_line1_to_line2};

	////////////////////////////////////////////////////////////////////////
	// per-phase measurement

	phase_meas_if meas_if [3] ();

	for (genvar p = 0; p < freq_prot_pkg::NUM_PHASE; p++) begin : g_phase
		phase_meter u_meter (
			.clk          (clk),
			.rst_n        (rst_n),
			.sample_valid (sample_valid),
			.sample       (volts[p]),
			.uv_threshold (s_r.uv_thr),
			.win_meas     (s_r.win_meas),
			.win_in       (s_r.win_in),
			.win_out      (s_r.win_out),
			.meas         (meas_if[p])
		);
		assign ph_freq[p] = meas_if[p].freq;
		assign ph_grad[p] = meas_if[p].grad;
		assign ph_low[p] = meas_if[p].low_volt;
	end

	////////////////////////////////////////////////////////////////////////
	// recovery timing, counted in millisecond ticks

	assign tick = (s_r.tick_cnt == 32'(TICK_CYCLES - 1));
	assign blocked = s_r.all_low || (s_r.recov < freq_prot_pkg::BLOCK_HOLD_TICKS);
	assign freq_zero = s_r.all_low || (s_r.recov < freq_prot_pkg::FREQ_ZERO_TICKS);
	assign grad_zero = s_r.all_low || (s_r.recov < freq_prot_pkg::GRAD_ZERO_TICKS);

	////////////////////////////////////////////////////////////////////////
	// one element, one phase: is the selected condition met

	function automatic logic phase_cond(
		input freq_prot_pkg::mode_type m,
		input freq_prot_pkg::pol_type  pl,
		input logic [15:0]             f,
		input logic signed [15:0]      g,
		input logic [15:0]             ft,
		input logic [15:0]             gt
	);
		logic              under;
		logic              over;
		logic              grad_hit;
		logic signed [16:0] gs;
		logic signed [16:0] lim;
		under = (f < ft);
		over = (f > ft);
		gs = 17'(g);
		lim = $signed({1'b0, gt});
		// direction by polarity setting
		unique case (pl)
			freq_prot_pkg::POL_RISE: grad_hit = (gs > lim);
			freq_prot_pkg::POL_FALL: grad_hit = (gs < -lim);
			freq_prot_pkg::POL_ABS:  grad_hit = (gs > lim) || (gs < -lim);
			default:                 grad_hit = 1'b0;
		endcase
		unique case (m)
			freq_prot_pkg::MODE_UNDER:      phase_cond = under;
			freq_prot_pkg::MODE_OVER:       phase_cond = over;
			freq_prot_pkg::MODE_RATE:       phase_cond = grad_hit;
			freq_prot_pkg::MODE_UNDER_GRAD: phase_cond = under && grad_hit;
			freq_prot_pkg::MODE_OVER_GRAD:  phase_cond = over && grad_hit;
			default:                        phase_cond = 1'b0;
		endcase
	endfunction

	function automatic logic [3:0] clamp(input logic [3:0] v, input logic [3:0] lo, input logic [3:0] hi);
		clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [2:0]         ei;
		logic               elem_hit;
		logic               cond;
		logic               pickup;
		logic [15:0]        f;
		logic signed [15:0] g;
		logic [31:0]        rd;
		ei = '0;
		elem_hit = 1'b0;
		cond = 1'b0;
		pickup = 1'b0;
		f = '0;
		g = '0;
		rd = '0;
		s_nxt = s_r;

		s_nxt.tick_cnt = tick ? 32'h0000_0000 : s_r.tick_cnt + 32'h0000_0001;
		s_nxt.blk_s1 = ext_block;
		s_nxt.blk_s2 = s_r.blk_s1;

		// hold timers restart whenever all three are low again
		s_nxt.all_low = &ph_low;
		if (s_r.all_low)
			s_nxt.recov = '0;
		else if (tick && s_r.recov < freq_prot_pkg::GRAD_ZERO_TICKS)
			s_nxt.recov = s_r.recov + 10'h001;

		// six independent elements
		for (int e = 0; e < freq_prot_pkg::NUM_ELEM; e++) begin
			cond = 1'b0;
			for (int p = 0; p < freq_prot_pkg::NUM_PHASE; p++) begin
				f = freq_zero ? 16'h0000 : ph_freq[p];
				g = grad_zero ? 16'sh0000 : $signed(ph_grad[p]);
				// any single measurable phase is enough
				if (!ph_low[p] && phase_cond(s_r.mode[e], s_r.pol[e], f, g, s_r.fthr[e], s_r.gthr[e]))
					cond = 1'b1;
			end
			pickup = cond && !blocked && !s_r.blk_s2[e];
			if (!pickup) begin
				// dropout before expiry: no trip, timer cleared
				s_nxt.timer[e] = '0;
				s_nxt.alarm[e] = 1'b0;
				s_nxt.trip[e] = 1'b0;
			end else begin
				s_nxt.alarm[e] = 1'b1;
				if (tick && s_r.timer[e] < s_r.delay[e])
					s_nxt.timer[e] = s_r.timer[e] + 16'h0001;
				// condition still present at expiry
				s_nxt.trip[e] = (s_nxt.timer[e] >= s_r.delay[e]);
			end
		end

		// register writes
		ei = 3'(reg_addr[7:4] - freq_prot_pkg::ELEM_BASE_IDX);
		elem_hit = (reg_addr[7:4] >= freq_prot_pkg::ELEM_BASE_IDX) && (ei < 3'(freq_prot_pkg::NUM_ELEM))
			&& (reg_addr[1:0] == 2'h0);
		if (reg_we) begin
			if (reg_addr == freq_prot_pkg::ADDR_UV)
				s_nxt.uv_thr = reg_wdata[15:0];
			if (reg_addr == freq_prot_pkg::ADDR_WIN) begin
				s_nxt.win_meas = clamp(reg_wdata[freq_prot_pkg::WIN_MEAS_LSB +: 4],
					freq_prot_pkg::WIN_MEAS_MIN, freq_prot_pkg::WIN_MEAS_MAX);
				s_nxt.win_in = clamp(reg_wdata[freq_prot_pkg::WIN_IN_LSB +: 4],
					freq_prot_pkg::SMOOTH_MIN, freq_prot_pkg::SMOOTH_MAX);
				s_nxt.win_out = clamp(reg_wdata[freq_prot_pkg::WIN_OUT_LSB +: 4],
					freq_prot_pkg::SMOOTH_MIN, freq_prot_pkg::SMOOTH_MAX);
			end
			if (elem_hit) begin
				unique case (reg_addr[3:2])
					freq_prot_pkg::EF_CFG: begin
						s_nxt.mode[ei] = freq_prot_pkg::mode_type'(reg_wdata[freq_prot_pkg::CFG_MODE_LSB +: 3]);
						s_nxt.pol[ei] = freq_prot_pkg::pol_type'(reg_wdata[freq_prot_pkg::CFG_POL_LSB +: 2]);
					end
					freq_prot_pkg::EF_FTHR:  s_nxt.fthr[ei] = reg_wdata[15:0];
					freq_prot_pkg::EF_GTHR:  s_nxt.gthr[ei] = reg_wdata[15:0];
					freq_prot_pkg::EF_DELAY: s_nxt.delay[ei] = reg_wdata[15:0];
				endcase
			end
		end

		// register reads, data valid in the next cycle only
		if (reg_re) begin
			if (reg_addr == freq_prot_pkg::ADDR_UV)
				rd[15:0] = s_r.uv_thr;
			if (reg_addr == freq_prot_pkg::ADDR_WIN) begin
				rd[freq_prot_pkg::WIN_MEAS_LSB +: 4] = s_r.win_meas;
				rd[freq_prot_pkg::WIN_IN_LSB +: 4] = s_r.win_in;
				rd[freq_prot_pkg::WIN_OUT_LSB +: 4] = s_r.win_out;
			end
			if (reg_addr == freq_prot_pkg::ADDR_STATUS) begin
				rd[freq_prot_pkg::ST_ALARM_LSB +: 6] = s_r.alarm;
				rd[freq_prot_pkg::ST_TRIP_LSB +: 6] = s_r.trip;
				rd[freq_prot_pkg::ST_BLOCK_BIT] = blocked;
			end
			for (int p = 0; p < freq_prot_pkg::NUM_PHASE; p++) begin
				if (reg_addr == freq_prot_pkg::ADDR_PHASE0 + 8'(4 * p)) begin
					rd[15:0] = freq_zero ? 16'h0000 : ph_freq[p];
					rd[freq_prot_pkg::PH_GRAD_LSB +: 16] = grad_zero ? 16'h0000 : ph_grad[p];
				end
			end
			if (elem_hit) begin
				unique case (reg_addr[3:2])
					freq_prot_pkg::EF_CFG: begin
						rd[freq_prot_pkg::CFG_MODE_LSB +: 3] = s_r.mode[ei];
						rd[freq_prot_pkg::CFG_POL_LSB +: 2] = s_r.pol[ei];
					end
					freq_prot_pkg::EF_FTHR:  rd[15:0] = s_r.fthr[ei];
					freq_prot_pkg::EF_GTHR:  rd[15:0] = s_r.gthr[ei];
					freq_prot_pkg::EF_DELAY: rd[15:0] = s_r.delay[ei];
				endcase
			end
		end
		s_nxt.rdata = rd;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.all_low <= 1'b1;
			s_r.uv_thr <= freq_prot_pkg::UV_THR_RST;
			s_r.win_meas <= freq_prot_pkg::WIN_MEAS_RST;
			s_r.win_in <= freq_prot_pkg::WIN_IN_RST;
			s_r.win_out <= freq_prot_pkg::WIN_OUT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign reg_rdata = s_r.rdata;
	assign alarm = s_r.alarm;
	assign trip = s_r.trip;
	// blocking on a short recovery is kept on purpose, not a glitch
	assign freq_blocked = blocked;
endmodule // frequency_protection_element

// *** shared/freq_prot_pkg.sv ***
// constants and types shared by the frequency protection core
package freq_prot_pkg;
	localparam int NUM_ELEM      = 6;
	localparam int NUM_PHASE     = 3;
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_NS       = 1_000_000;
	localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
	localparam int BLOCK_HOLD_MS = 500;
	localparam int FREQ_ZERO_MS  = 300;
	localparam int GRAD_ZERO_MS  = 1000;
	localparam logic [9:0] BLOCK_HOLD_TICKS = 10'(BLOCK_HOLD_MS * 1_000_000 / TICK_NS);
	localparam logic [9:0] FREQ_ZERO_TICKS  = 10'(FREQ_ZERO_MS * 1_000_000 / TICK_NS);
	localparam logic [9:0] GRAD_ZERO_TICKS  = 10'(GRAD_ZERO_MS * 1_000_000 / TICK_NS);
	// clock rate times 100: period in cycles divides into centihertz
	localparam logic [63:0] FREQ_NUM_WIDE = 64'h0000_0017_4876_E800 / 64'(CLK_PERIOD_NS);
	localparam logic [34:0] FREQ_NUM      = 35'(FREQ_NUM_WIDE);
	localparam logic [8:0]  F_NOM_HZ      = 9'h032;
	// register map, byte addresses
	localparam logic [7:0] ADDR_UV       = 8'h00;
	localparam logic [7:0] ADDR_WIN      = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_PHASE0   = 8'h0C;
	localparam logic [3:0] ELEM_BASE_IDX = 4'h2;
	localparam logic [1:0] EF_CFG        = 2'h0;
	localparam logic [1:0] EF_FTHR       = 2'h1;
	localparam logic [1:0] EF_GTHR       = 2'h2;
	localparam logic [1:0] EF_DELAY      = 2'h3;
	// field positions
	localparam int WIN_MEAS_LSB = 0;
	localparam int WIN_IN_LSB   = 4;
	localparam int WIN_OUT_LSB  = 8;
	localparam int ST_ALARM_LSB = 0;
	localparam int ST_TRIP_LSB  = 8;
	localparam int ST_BLOCK_BIT = 16;
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_POL_LSB  = 4;
	localparam int PH_GRAD_LSB  = 16;
	// reset values and limits
	localparam logic [15:0] UV_THR_RST   = 16'h0400;
	localparam logic [3:0]  WIN_MEAS_RST = 4'h2;
	localparam logic [3:0]  WIN_IN_RST   = 4'h3;
	localparam logic [3:0]  WIN_OUT_RST  = 4'h1;
	localparam logic [3:0]  WIN_MEAS_MIN = 4'h2;
	localparam logic [3:0]  WIN_MEAS_MAX = 4'hA;
	localparam logic [3:0]  SMOOTH_MIN   = 4'h1;
	localparam logic [3:0]  SMOOTH_MAX   = 4'h8;

	typedef enum logic [2:0] {
		MODE_OFF, MODE_UNDER, MODE_OVER, MODE_RATE, MODE_UNDER_GRAD, MODE_OVER_GRAD
	} mode_type;
	typedef enum logic [1:0] {POL_RISE, POL_FALL, POL_ABS} pol_type;

	// 65536 / n for window lengths 1 to 10
	function automatic logic [17:0] recip(input logic [3:0] n);
		recip = (n == 4'h0) ? 18'h1_0000 : 18'(18'h1_0000 / 18'(n));
	endfunction
endpackage

// *** shared/phase_meas_if.sv ***
// per-phase frequency and gradient results
`timescale 1ns/1ns
interface phase_meas_if;
	logic [15:0]        freq;
	logic signed [15:0] grad;
	logic               low_volt;
	logic               upd;
	modport meter (output freq, output grad, output low_volt, output upd);
	modport core (input freq, input grad, input low_volt, input upd);
endinterface // phase_meas_if

// *** core/phase_meter.sv ***
// zero-crossing frequency and gradient measurement of one voltage
`timescale 1ns/1ns
module phase_meter (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// voltage samples
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] sample,
	// settings
	input  wire logic [15:0]        uv_threshold,
	input  wire logic [3:0]         win_meas,
	input  wire logic [3:0]         win_in,
	input  wire logic [3:0]         win_out,
	// results
	phase_meas_if.meter             meas
);
	typedef struct packed {
		logic               prev_neg;
		logic [23:0]        period;
		logic [15:0]        peak;
		logic               busy;
		logic [5:0]         step;
		logic [35:0]        rem;
		logic [34:0]        quot;
		logic [23:0]        divisor;
		logic               done;
		logic               low_volt;
		logic [15:0]        freq;
		logic [7:0][15:0]   hist_raw;
		logic [10:0][15:0]  hist_avg;
		logic [7:0][15:0]   hist_grad;
		logic [15:0]        grad;
		logic               upd;
	} meter_state_type;

	meter_state_type s_r;
	meter_state_type s_nxt;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [35:0]       r;
		logic [15:0]       raw;
		logic [15:0]       mag;
		logic [15:0]       avg;
		logic [15:0]       best;
		logic [15:0]       bmag;
		logic [18:0]       sum;
		logic [7:0][15:0]  hr;
		logic [7:0][15:0]  hg;
		logic [10:0][15:0] ha;
		logic signed [16:0] diff;
		logic signed [43:0] prod;
		logic signed [27:0] scaled;
		r = '0;
		raw = '0;
		mag = '0;
		avg = '0;
		best = '0;
		bmag = '0;
		sum = '0;
		hr = '0;
		hg = '0;
		ha = '0;
		diff = '0;
		prod = '0;
		scaled = '0;
		s_nxt = s_r;
		s_nxt.upd = 1'b0;
		s_nxt.done = 1'b0;
		// serial divide, one quotient bit a cycle
		if (s_r.busy) begin
			r = {s_r.rem[34:0], freq_prot_pkg::FREQ_NUM[s_r.step]};
			if (r >= 36'(s_r.divisor)) begin
				r = r - 36'(s_r.divisor);
				s_nxt.quot[s_r.step] = 1'b1;
			end
			s_nxt.rem = r;
			if (s_r.step == 6'h00) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.step = s_r.step - 6'h01;
			end
		end
		if (sample_valid) begin
			s_nxt.prev_neg = sample[15];
			s_nxt.period = (&s_r.period) ? s_r.period : s_r.period + 24'h00_0001;
			mag = sample[15] ? 16'(-sample) : 16'(sample);
			if (mag > s_r.peak)
				s_nxt.peak = mag;
			if (s_r.prev_neg && !sample[15]) begin
				// whole cycle timed between rising crossings
				s_nxt.low_volt = (s_r.peak < uv_threshold);
				s_nxt.divisor = s_r.period;
				// the crossing sample opens the next period, so it counts as one
				s_nxt.period = 24'h00_0001;
				s_nxt.peak = '0;
				s_nxt.busy = 1'b1;
				s_nxt.step = 6'h22;
				s_nxt.rem = '0;
				s_nxt.quot = '0;
			end else if (s_r.period == 24'hFF_FFFE) begin
				// no crossing for too long: voltage is gone
				s_nxt.low_volt = 1'b1;
				s_nxt.freq = '0;
				s_nxt.upd = 1'b1;
			end
		end
		if (s_r.done) begin
			raw = (|s_r.quot[34:16]) ? 16'hFFFF : s_r.quot[15:0];
			s_nxt.freq = raw;
			// gradient built from averaged values, not the raw ones
			hr = {s_r.hist_raw[6:0], raw};
			for (int i = 0; i < 8; i++)
				if (4'(i) < win_in)
					sum = sum + 19'(hr[i]);
			avg = 16'((37'(sum) * 37'(freq_prot_pkg::recip(win_in))) >> 16);
			ha = {s_r.hist_avg[9:0], avg};
			// difference across the measuring window, scaled per second
			diff = $signed({1'b0, ha[0]}) - $signed({1'b0, ha[win_meas]});
			prod = 44'(diff) * 44'(freq_prot_pkg::F_NOM_HZ) * 44'(freq_prot_pkg::recip(win_meas));
			scaled = 28'(prod >>> 16);
			// positive while rising, negative while falling
			if (scaled > 28'sh000_7FFF)
				raw = 16'h7FFF;
			else if (scaled < -28'sh000_7FFF)
				raw = 16'h8001;
			else
				raw = 16'(scaled);
			hg = {s_r.hist_grad[6:0], raw};
			// least magnitude in window rejects single spikes
			best = hg[0];
			bmag = hg[0][15] ? 16'(-hg[0]) : hg[0];
			for (int i = 1; i < 8; i++) begin
				mag = hg[i][15] ? 16'(-hg[i]) : hg[i];
				if (4'(i) < win_out && mag < bmag) begin
					best = hg[i];
					bmag = mag;
				end
			end
			s_nxt.hist_raw = hr;
			s_nxt.hist_avg = ha;
			s_nxt.hist_grad = hg;
			s_nxt.grad = best; // one new value each period
			s_nxt.upd = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '0;
			s_r.low_volt <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign meas.freq = s_r.freq;
	assign meas.grad = s_r.grad;
	assign meas.low_volt = s_r.low_volt;
	assign meas.upd = s_r.upd;
endmodule // phase_meter

// *** testbench/freq_prot_assertions.sv ***
// port-level assertions for the frequency protection core
`timescale 1ns/1ns
module freq_prot_assertions #(
	parameter int TICK_CYCLES = 10
) (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst_n,
	// blocking and register port
	input wire logic [5:0]  ext_block,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_re,
	input wire logic [31:0] reg_rdata,
	// protection outputs
	input wire logic [5:0]  alarm,
	input wire logic [5:0]  trip,
	input wire logic        freq_blocked
);
	localparam int HOLD_CYC = TICK_CYCLES * int'(freq_prot_pkg::BLOCK_HOLD_TICKS);
	// blocking outlasts the forced zero frequency, so only the early part of a spell is checked
	localparam int FZ_CYC   = TICK_CYCLES * (int'(freq_prot_pkg::FREQ_ZERO_TICKS) - 1);
	int blk_cnt_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// counts how long the current blocking spell has lasted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			blk_cnt_r <= 0;
		else if (!freq_blocked)
			blk_cnt_r <= 0;
		else
			blk_cnt_r <= blk_cnt_r + 1;
	end

	////////////////////////////////////////////////////////////////////////////
	sequence status_rd_s;
		reg_re && reg_addr == freq_prot_pkg::ADDR_STATUS;
	endsequence
	sequence quiet_s;
		$stable(alarm) && $stable(trip) && $stable(freq_blocked);
	endsequence
	sequence phase_rd_s;
		reg_re && reg_addr == freq_prot_pkg::ADDR_PHASE0 && freq_blocked && blk_cnt_r < FZ_CYC;
	endsequence

	blocked_quiet_a: assert property (freq_blocked && $past(freq_blocked) |-> alarm == 6'h00 && trip == 6'h00)
		else $error("alarm or trip while frequency blocked");
	ext_quiet_a: assert property ((ext_block & $past(ext_block) & $past(ext_block, 2) & $past(ext_block, 3) & alarm) == 6'h00)
		else $error("alarm on externally blocked element");
	trip_alarm_a: assert property ((trip & ~alarm) == 6'h00)
		else $error("trip without alarm");
	trip_stands_a: assert property (((($past(trip) & ~trip)) & alarm) == 6'h00)
		else $error("trip dropped while alarm held");
	rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read answer cycle");
	block_hold_a: assert property ($fell(freq_blocked) |-> blk_cnt_r >= HOLD_CYC)
		else $error("blocking released too early");
	phase_zero_a: assert property (phase_rd_s |=> reg_rdata[15:0] == 16'h0000)
		else $error("frequency nonzero while blocked");
	status_read_a: assert property (status_rd_s ##1 quiet_s |->
		reg_rdata[5:0] == alarm && reg_rdata[13:8] == trip && reg_rdata[16] == freq_blocked)
		else $error("status word disagrees with outputs");
endmodule // freq_prot_assertions

bind frequency_protection_element freq_prot_assertions #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
	.clk(clk), .rst_n(rst_n), .ext_block(ext_block), .reg_addr(reg_addr), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .alarm(alarm), .trip(trip), .freq_blocked(freq_blocked)
);

// *** testbench/line_voltage_source.sv ***
// triangle-wave three-phase line voltage source
`timescale 1ns/1ns
module line_voltage_source #(
	parameter int PERIOD = 390625,
	parameter int AMPL   = 8192
) (
	// clock and reset
	input wire logic           clk,
	input wire logic           rst_n,
	// samples
	output logic               sample_valid,
	output logic signed [15:0] voltage_line1_to_line2,
	output logic signed [15:0] voltage_line2_to_line3,
	output logic signed [15:0] voltage_line3_to_line1
);
	int ph_r;

	// rising zero crossing at a quarter period
	function automatic logic signed [15:0] tri_wave(input int p);
		longint q;
		q = longint'(p % PERIOD) * 4 * AMPL / PERIOD;
		tri_wave = 16'(q < 2 * AMPL ? q - AMPL : 3 * AMPL - q);
	endfunction

	// starts just short of a crossing so the first period is not wasted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_r         <= PERIOD / 4 - 64;
			sample_valid <= 1'b0;
		end else begin
			ph_r         <= (ph_r + 1) % PERIOD;
			sample_valid <= 1'b1;
		end
	end
	assign voltage_line1_to_line2 = tri_wave(ph_r);
	assign voltage_line2_to_line3 = tri_wave(ph_r + PERIOD / 3);
	assign voltage_line3_to_line1 = tri_wave(ph_r + 2 * PERIOD / 3);
endmodule // line_voltage_source

// *** testbench/testbench.sv ***
// self-checking bench for the frequency protection core
`timescale 1ns/1ns
module testbench;
	// period whose frequency reads 64000, inside the 16-bit reading
	localparam int PER = 390625;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	logic               sample_valid;
	logic signed [15:0] v12, v23, v31;
	logic [5:0]         ext_block = 6'h08;
	logic [7:0]         reg_addr = 8'h00;
	logic [31:0]        reg_wdata = 32'h0000_0000;
	logic               reg_we = 1'b0;
	logic               reg_re = 1'b0;
	logic [31:0]        reg_rdata, rd_v;
	logic [5:0]         alarm, trip, exp_al;
	logic               freq_blocked;
	logic [15:0]        thr [6];
	logic [2:0]         md [6];
	logic [31:0]        rnd = 32'h9260_c5ed;
	int                 n_errors = 0;
	int                 checks_done = 0;

	always #2 clk = ~clk;

	line_voltage_source #(.PERIOD(PER)) src_u (.clk(clk), .rst_n(rst_n), .sample_valid(sample_valid),
		.voltage_line1_to_line2(v12), .voltage_line2_to_line3(v23), .voltage_line3_to_line1(v31));
	frequency_protection_element #(.TICK_CYCLES(10)) dut_u (.clk(clk), .rst_n(rst_n),
		.sample_valid(sample_valid), .voltage_line1_to_line2(v12), .voltage_line2_to_line3(v23),
		.voltage_line3_to_line1(v31), .ext_block(ext_block), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .alarm(alarm), .trip(trip),
		.freq_blocked(freq_blocked));

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [15:0] exp_freq(input int p);
		exp_freq = 16'(freq_prot_pkg::FREQ_NUM / 35'(p));
	endfunction
	function automatic logic pick(input logic [2:0] m, input logic [15:0] f, input logic [15:0] t);
		pick = (m == 3'h1 && f < t) || (m == 3'h2 && f > t);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_we    <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_re   <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
		@(posedge clk);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a, rd_v);
		chk(nm, e, rd_v);
	endtask
	task automatic finish_test();
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		rnd = lfsr(lfsr(rnd));
		md = '{3'h1, 3'h2, 3'h1, 3'h2, 3'h4, 3'h3};
		thr = '{16'(64001 + rnd[8:0]), 16'(63999 - rnd[20:12]), 16'hFA00, 16'hF618, 16'hFDE8, 16'hFA00};
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk("uv_thr", 8'h00, 32'h0000_0400);
		rchk("windows", 8'h04, 32'h0000_0132);
		wr(8'h04, 32'h0000_08FF);
		rchk("win_hi", 8'h04, 32'h0000_088A);
		wr(8'h04, 32'h0000_0100);
		rchk("win_lo", 8'h04, 32'h0000_0112);
		wr(8'h04, 32'h0000_0132);
		rchk("unmapped", 8'h1C, 32'h0000_0000);
		rchk("blk_phase", 8'h0C, 32'h0000_0000);
		rchk("blk_status", 8'h08, 32'h0001_0000);
		for (int i = 0; i < 6; i++) begin
			wr(8'(32 + 16 * i), 32'(md[i]));
			wr(8'(36 + 16 * i), 32'(thr[i]));
			wr(8'(40 + 16 * i), 32'h0000_7FFF);
			wr(8'(44 + 16 * i), i == 0 ? 32'h0000_0002 : 32'h0000_FFFF);
			exp_al[i] = pick(md[i], exp_freq(PER), thr[i]) && !ext_block[i];
		end
		// every phase has seen two crossings by now
		repeat (2 * PER) @(posedge clk);
		#1 chk("blocked", 32'h0000_0000, 32'(freq_blocked));
		chk("alarm", 32'(exp_al), 32'(alarm));
		chk("trip", 32'h0000_0001, 32'(trip));
		@(posedge clk);
		rd(8'h0C, rd_v);
		chk("freq_ph0", 32'(exp_freq(PER)), 32'(rd_v[15:0]));
		rd(8'h14, rd_v);
		chk("freq_ph2", 32'(exp_freq(PER)), 32'(rd_v[15:0]));
		rchk("status", 8'h08, {16'h0000, 2'h0, 6'h01, 2'h0, exp_al});
		wr(8'h24, 32'h0000_0000);
		repeat (3) @(posedge clk);
		#1 chk("drop_al", 32'h0000_0000, 32'(alarm[0]));
		chk("drop_tr", 32'h0000_0000, 32'(trip[0]));
		@(posedge clk);
		wr(8'h24, 32'(thr[0]));
		repeat (3) @(posedge clk);
		#1 chk("re_al", 32'h0000_0001, 32'(alarm[0]));
		chk("re_tr", 32'h0000_0000, 32'(trip[0]));
		repeat (30) @(posedge clk);
		#1 chk("late_tr", 32'h0000_0001, 32'(trip[0]));
		finish_test();
	end

	initial begin
		repeat (2 * PER + 20000) @(posedge clk);
		n_errors++;
		finish_test();
	end
endmodule // testbench
